// ==== rtl/aout_consts.svh ====
// Constants for the analog output host exchange port
`ifndef AOUT_CONSTS_SVH
`define AOUT_CONSTS_SVH
// ---------------------------------------------
// Word offsets and status word fields
// ---------------------------------------------
`define RD_RESULT_OFS      2'h2
`define STATUS_OFS         2'h3
`define ST_INVALID         3
`define ST_CONV_ERR        4
`define ST_SPEED           5
`define ST_RD_DONE         6
`define ST_WR_DONE         7
`define ST_LIMIT           8
`define ST_EXT_PWR         9
`define ST_SEQ_ERR         10
`define ST_PULSE           11
`define ST_OK              12
// ---------------------------------------------
// Command word fields
// ---------------------------------------------
`define CMD_REQ            0
`define CMD_NV_WRITE       3
`define CMD_PARAM_UPD      5
`define CMD_HOST_WR_DONE   6
`define CMD_HOST_RD_DONE   7
`define CMD_PTR_LO         8
`define CMD_PTR_HI         15
// ---------------------------------------------
// RAM layout
// ---------------------------------------------
`define RAM_WORDS          62
`define RAM_FLAGS_ADDR     6'h00
`define RAM_DATA_FIRST     6'h01
`define RAM_DATA_LAST      6'h08
`define RAM_MODE_ADDR      6'h0E
`define RAM_MODE_FLAG_ADDR 6'h0A
`define RAM_UPPER_FIRST    6'h10
`define RAM_LOWER_FIRST    6'h18
`define RAM_RAMP_FIRST     6'h20
`define RAM_RAMP_LAST      6'h27
`define MODE_RESET         16'hFF00
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define CLK_HZ             200000000
`define PULSE_HALF_MS      500
`define PULSE_HALF_CYC     ((`CLK_HZ / 1000) * `PULSE_HALF_MS)
`define SEQ_TIMEOUT_MS     1000
`define SEQ_TIMEOUT_CYC    ((`CLK_HZ / 1000) * `SEQ_TIMEOUT_MS)
`endif

// ==== rtl/aout_host_port.sv ====
// Host exchange port: command capture, RAM access and status word
`default_nettype none
`include "aout_consts.svh"

// Notes on behaviour
// - A read request copies the pointed RAM word into the read result word.
// - Invalid data sets the invalid flag, is discarded; valid write clears it.
// - Conversion error sets its flag, configuration kept; valid write clears it.
// - Speed bit set means normal speed, clear means high speed.
// - After taking write data and command, raise the read-done flag.
// - After loading the read result word, raise the write-done flag.
// - Out-of-limit conversion data sets limit flag; in-range write clears it. Code compares limits only for points in binary format.
// - External supply flag follows the external power supply state.
// - Abnormal handshake end sets sequence error; host read-done edge clears it.
// - While sequence error stands, every host read and write is ignored.
// - Heartbeat toggles at 1 Hz, half second high, half second low.
// - Heartbeat pauses during a nonvolatile store write, then resumes.
// - OK flag set after clean self-diagnosis, cleared on internal error.
// - Internal RAM holds 62 words of 16 bits.
// - Format per point, BCD by default, shared by all values of a point.
// - BCD signed values use bit 15 as sign, BCD magnitude below.
// - Ranges: unipolar 0..4095, bipolar -2048..2047, scaled wider.
// - Ramp times are unsigned; negative ramp values are rejected.
// - Host writes control bits; module alone writes flags.
// - Bits 0-7 and 8-15 of control words map to points 1-8.
// - Host raises read-done after reading; module drops write-done.
module aout_host_port #(
    parameter int PULSE_HALF_CYC  = `PULSE_HALF_CYC,
    parameter int SEQ_TIMEOUT_CYC = `SEQ_TIMEOUT_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic [15:0] WRITE_DATA,
    input  wire logic [15:0] COMMAND,
    input  wire logic        SPEED_NORMAL,
    input  wire logic        EXT_POWER_ON,
    input  wire logic        CONV_FAULT,
    input  wire logic        DIAG_DONE,
    input  wire logic        DIAG_FAULT,
    input  wire logic        NV_WRITE_BUSY,
    input  wire logic [7:0]  BIPOLAR_POINTS,
    output logic      [15:0] READ_RESULT_WORD,
    output logic      [15:0] MODULE_STATUS_WORD,
    output logic             SPEED_IS_HIGH,
    output logic             NV_WRITE_REQ,
    output logic             PARAM_UPDATE_REQ
);
    // ---------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------
    logic [15:0] wdata_s;
    logic [15:0] cmd_s;
    logic [7:0]  misc_s;
    logic [7:0]  bip_s;

    aout_sync #(.WIDTH(16)) u_sync_wdata (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   (WRITE_DATA),
        .dout  (wdata_s)
    );
    aout_sync #(.WIDTH(16)) u_sync_cmd (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   (COMMAND),
        .dout  (cmd_s)
    );
    aout_sync #(.WIDTH(8)) u_sync_misc (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   ({2'h0, SPEED_NORMAL, EXT_POWER_ON, CONV_FAULT, DIAG_DONE, DIAG_FAULT, NV_WRITE_BUSY}),
        .dout  (misc_s)
    );
    aout_sync #(.WIDTH(8)) u_sync_bip (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   (BIPOLAR_POINTS),
        .dout  (bip_s)
    );

    logic speed_s;
    logic ext_s;
    logic conv_s;
    logic diag_done_s;
    logic diag_fault_s;
    logic nv_busy_s;
    assign speed_s      = misc_s[5];
    assign ext_s        = misc_s[4];
    assign conv_s       = misc_s[3];
    assign diag_done_s  = misc_s[2];
    assign diag_fault_s = misc_s[1];
    assign nv_busy_s    = misc_s[0];

    // ---------------------------------------------
    // Command decode
    // ---------------------------------------------
    logic       host_write_done;
    logic       host_read_done;
    logic       req_write;
    logic [3:0] ptr_tens;
    logic [3:0] ptr_ones;
    logic [5:0] ptr;
    logic       ptr_ok;

    assign host_write_done = cmd_s[`CMD_HOST_WR_DONE];
    assign host_read_done  = cmd_s[`CMD_HOST_RD_DONE];
    assign req_write       = cmd_s[`CMD_REQ];
    assign ptr_tens        = cmd_s[`CMD_PTR_HI:`CMD_PTR_HI-3];
    assign ptr_ones        = cmd_s[`CMD_PTR_LO+3:`CMD_PTR_LO];
    assign ptr             = 6'(ptr_tens * 10 + ptr_ones);
    // Pointer is two BCD digits; 64 to 99 wrap to 0 to 35, any other bad pointer on a write is treated as invalid data
    assign ptr_ok          = (ptr_tens < 4'hA) && (ptr_ones < 4'hA) && (ptr < 6'(`RAM_WORDS));

    // ---------------------------------------------
    // Point RAM
    // ---------------------------------------------
    logic [15:0] ram_q [`RAM_WORDS];
    logic [15:0] mode_word;
    logic [2:0]  pt_idx;
    logic        pt_bcd;
    logic        pt_scaled;
    logic        pt_bipolar;
    logic        val_ok;
    logic        is_data;
    logic        limit_hit;
    logic        host_ctrl_word;
    logic [15:0] upper;
    logic [15:0] lower;

    assign mode_word  = ram_q[`RAM_MODE_ADDR];
    assign pt_idx     = 3'(ptr - ((ptr >= `RAM_RAMP_FIRST) ? `RAM_RAMP_FIRST : `RAM_DATA_FIRST));
    assign pt_bcd     = mode_word[8 + pt_idx];
    assign pt_scaled  = ram_q[`RAM_MODE_ADDR - 6'h1][pt_idx];
    assign pt_bipolar = bip_s[pt_idx];
    assign is_data    = (ptr >= `RAM_DATA_FIRST) && (ptr <= `RAM_DATA_LAST);
    assign upper      = ram_q[`RAM_UPPER_FIRST + 6'(pt_idx)];
    assign lower      = ram_q[`RAM_LOWER_FIRST + 6'(pt_idx)];
    // Limit compare is plain signed; only meaningful in binary format
    assign limit_hit  = is_data && !pt_bcd && (upper != 16'h0000)
                        && (($signed(wdata_s) > $signed(upper)) || ($signed(wdata_s) < $signed(lower)));
    // Flag words are module-owned; host writes to them are refused
    assign host_ctrl_word = is_data || (ptr > `RAM_MODE_FLAG_ADDR);

    aout_value_check u_check (
        .addr     (ptr),
        .data     (wdata_s),
        .bcd_mode (pt_bcd),
        .bipolar  (pt_bipolar),
        .scaled   (pt_scaled),
        .valid    (val_ok)
    );

    // ---------------------------------------------
    // Handshake state machine
    // ---------------------------------------------
    aout_pkg::xfer_state_t state_q;
    logic        rd_done_q;
    logic        wr_done_q;
    logic        seq_err_q;
    logic        invalid_q;
    logic        conv_err_q;
    logic        limit_q;
    logic        do_write;
    logic        do_read;
    logic        good_write;
    logic        hrd_prev_q;
    logic        hrd_edge;
    logic [31:0] wait_cnt_q;
    logic        timeout;

    assign hrd_edge   = host_read_done ^ hrd_prev_q;
    assign timeout    = (wait_cnt_q >= 32'(SEQ_TIMEOUT_CYC - 1));
    assign do_write   = (state_q == aout_pkg::XS_ACCESS) && req_write;
    assign do_read    = (state_q == aout_pkg::XS_ACCESS) && !req_write;
    assign good_write = do_write && ptr_ok && val_ok && host_ctrl_word && !limit_hit;

    // Sequence: take words, access RAM, report, wait for host to finish
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q   <= aout_pkg::XS_IDLE;
            rd_done_q <= 1'b0;
            wr_done_q <= 1'b0;
        end else begin
            case (state_q)
                aout_pkg::XS_IDLE: begin
                    if (host_write_done && !seq_err_q) begin
                        rd_done_q <= 1'b1;
                        state_q   <= aout_pkg::XS_ACCESS;
                    end
                end
                aout_pkg::XS_ACCESS: begin
                    state_q <= aout_pkg::XS_WAIT_WR;
                end
                aout_pkg::XS_WAIT_WR: begin
                    if (timeout) begin
                        rd_done_q <= 1'b0;
                        state_q   <= aout_pkg::XS_IDLE;
                    end else if (!host_write_done) begin
                        rd_done_q <= 1'b0;
                        wr_done_q <= 1'b1;
                        state_q   <= aout_pkg::XS_WAIT_RD;
                    end
                end
                aout_pkg::XS_WAIT_RD: begin
                    if (timeout) begin
                        wr_done_q <= 1'b0;
                        state_q   <= aout_pkg::XS_IDLE;
                    end else if (host_read_done) begin
                        wr_done_q <= 1'b0;
                        state_q   <= aout_pkg::XS_FINISH;
                    end
                end
                aout_pkg::XS_FINISH: begin
                    if (!host_read_done || timeout) begin
                        state_q <= aout_pkg::XS_IDLE;
                    end
                end
                default: begin
                    state_q <= aout_pkg::XS_IDLE;
                end
            endcase
        end
    end

    // Wait counter catches a host that stalls mid-handshake
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_cnt_q <= 32'h0000_0000;
        end else if (state_q == aout_pkg::XS_IDLE || state_q == aout_pkg::XS_ACCESS || timeout) begin
            wait_cnt_q <= 32'h0000_0000;
        end else begin
            wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
        end
    end

    // Sequence error: timeout sets; host read-done edge clears; set wins
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            hrd_prev_q <= 1'b0;
            seq_err_q  <= 1'b0;
        end else begin
            hrd_prev_q <= host_read_done;
            if (timeout && state_q != aout_pkg::XS_IDLE) begin
                seq_err_q <= 1'b1;
            end else if (hrd_edge) begin
                seq_err_q <= 1'b0;
            end
        end
    end

    // RAM writes from host, reset defaults put every point in BCD
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < `RAM_WORDS; i++) begin
                ram_q[i] <= 16'h0000;
            end
            ram_q[`RAM_MODE_ADDR]      <= `MODE_RESET;
            ram_q[`RAM_MODE_FLAG_ADDR] <= `MODE_RESET;
        end else begin
            if (good_write) begin
                ram_q[ptr] <= wdata_s;
            end
            ram_q[`RAM_FLAGS_ADDR] <= {{8{conv_s}}, ram_q[`RAM_FLAGS_ADDR][7:0]};
            if (do_write && !good_write && is_data && ptr_ok) begin
                ram_q[`RAM_FLAGS_ADDR][pt_idx] <= 1'b1;
            end else if (good_write && is_data) begin
                ram_q[`RAM_FLAGS_ADDR][pt_idx] <= 1'b0;
            end
            ram_q[`RAM_MODE_FLAG_ADDR] <= mode_word;
        end
    end

    // Read result loaded from the pointed word
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            READ_RESULT_WORD <= 16'h0000;
        end else if (do_read && ptr_ok) begin
            READ_RESULT_WORD <= ram_q[ptr];
        end
    end

    // Error flags: a bad write or a conversion fault sets, a good write clears
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            invalid_q  <= 1'b0;
            conv_err_q <= 1'b0;
            limit_q    <= 1'b0;
        end else begin
            if (do_write && !(ptr_ok && val_ok && host_ctrl_word)) begin
                invalid_q <= 1'b1;
            end else if (good_write) begin
                invalid_q <= 1'b0;
            end
            if (conv_s) begin
                conv_err_q <= 1'b1;
            end else if (good_write) begin
                conv_err_q <= 1'b0;
            end
            if (do_write && limit_hit) begin
                limit_q <= 1'b1;
            end else if (good_write && is_data) begin
                limit_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // Heartbeat and health
    // ---------------------------------------------
    logic [31:0] pulse_cnt_q;
    logic        pulse_q;
    logic        ok_q;

    // Counter freezes while the store write runs, so phase is kept
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pulse_cnt_q <= 32'h0000_0000;
            pulse_q     <= 1'b0;
        end else if (!nv_busy_s) begin
            if (pulse_cnt_q >= 32'(PULSE_HALF_CYC - 1)) begin
                pulse_cnt_q <= 32'h0000_0000;
                pulse_q     <= ~pulse_q;
            end else begin
                pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Fault dominates a diagnosis result in the same cycle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ok_q <= 1'b0;
        end else if (diag_fault_s) begin
            ok_q <= 1'b0;
        end else if (diag_done_s) begin
            ok_q <= 1'b1;
        end
    end

    // ---------------------------------------------
    // Status word and side outputs
    // ---------------------------------------------
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            MODULE_STATUS_WORD <= 16'h0000;
        end else begin
            MODULE_STATUS_WORD                <= 16'h0000;
            MODULE_STATUS_WORD[`ST_INVALID]   <= invalid_q;
            MODULE_STATUS_WORD[`ST_CONV_ERR]  <= conv_err_q;
            MODULE_STATUS_WORD[`ST_SPEED]     <= speed_s;
            MODULE_STATUS_WORD[`ST_RD_DONE]   <= rd_done_q;
            MODULE_STATUS_WORD[`ST_WR_DONE]   <= wr_done_q;
            MODULE_STATUS_WORD[`ST_LIMIT]     <= limit_q;
            MODULE_STATUS_WORD[`ST_EXT_PWR]   <= ext_s;
            MODULE_STATUS_WORD[`ST_SEQ_ERR]   <= seq_err_q;
            MODULE_STATUS_WORD[`ST_PULSE]     <= pulse_q;
            MODULE_STATUS_WORD[`ST_OK]        <= ok_q;
        end
    end

    // Speed select follows the pin every cycle; command strobes taken only with the handshake
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SPEED_IS_HIGH    <= 1'b0;
            NV_WRITE_REQ     <= 1'b0;
            PARAM_UPDATE_REQ <= 1'b0;
        end else begin
            SPEED_IS_HIGH    <= !speed_s;
            NV_WRITE_REQ     <= (state_q == aout_pkg::XS_ACCESS) && cmd_s[`CMD_NV_WRITE];
            PARAM_UPDATE_REQ <= (state_q == aout_pkg::XS_ACCESS) && cmd_s[`CMD_PARAM_UPD];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/aout_pkg.sv ====
// Types shared by the analog output host exchange port
`default_nettype none
package aout_pkg;
    typedef enum logic [2:0] {
        XS_IDLE    = 3'b000,
        XS_ACCESS  = 3'b001,
        XS_WAIT_WR = 3'b010,
        XS_WAIT_RD = 3'b011,
        XS_FINISH  = 3'b100
    } xfer_state_t;
endpackage
`default_nettype wire

// ==== rtl/aout_sync.sv ====
// Two-flop synchroniser for a bus of pin levels
`default_nettype none
module aout_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/aout_value_check.sv ====
// Range check of one word written into the point RAM
`default_nettype none
`include "aout_consts.svh"
module aout_value_check (
    input  wire logic [5:0]  addr,
    input  wire logic [15:0] data,
    input  wire logic        bcd_mode,
    input  wire logic        bipolar,
    input  wire logic        scaled,
    output logic             valid
);
    logic [3:0]  d0;
    logic [3:0]  d1;
    logic [3:0]  d2;
    logic [3:0]  d3;
    logic        neg;
    logic        digits_ok;
    logic [13:0] mag;
    logic        is_data;
    logic        is_ramp;

    assign d0 = data[3:0];
    assign d1 = data[7:4];
    assign d2 = data[11:8];
    assign d3 = {1'b0, data[14:12]};
    assign neg = data[15];
    assign is_data = (addr >= `RAM_DATA_FIRST) && (addr <= `RAM_DATA_LAST);
    assign is_ramp = (addr >= `RAM_RAMP_FIRST) && (addr <= `RAM_RAMP_LAST);
    // BCD magnitude: bit 15 is the sign, digits below it
    assign digits_ok = (d0 < 4'hA) && (d1 < 4'hA) && (d2 < 4'hA);
    assign mag = 14'(d3 * 1000 + d2 * 100 + d1 * 10 + d0);

    // Decide legality by format and mode; other words are unchecked
    always_comb begin
        valid = 1'b1;
        if (is_ramp) begin
            valid = bcd_mode ? (digits_ok && !neg) : !neg;
        end else if (is_data) begin
            if (bcd_mode) begin
                if (!digits_ok) begin
                    valid = 1'b0;
                end else if (scaled) begin
                    valid = 1'b1;
                end else if (bipolar) begin
                    valid = neg ? (mag <= 14'h0800) : (mag <= 14'h07FF);
                end else begin
                    valid = !neg && (mag <= 14'h0FFF);
                end
            end else if (scaled) begin
                valid = (data != 16'h8000);
            end else if (bipolar) begin
                valid = ($signed(data) >= -16'sh0800) && ($signed(data) <= 16'sh07FF);
            end else begin
                valid = (data <= 16'h0FFF);
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/aout_host_port_props.sv ====
// Concurrent checks on the analog output host exchange port
`default_nettype none
module aout_host_port_props #(
    parameter int SEQ_TIMEOUT_CYC = 50
) (
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    input wire logic [15:0] COMMAND,
    input wire logic        SPEED_NORMAL,
    input wire logic        EXT_POWER_ON,
    input wire logic        DIAG_FAULT,
    input wire logic        NV_WRITE_BUSY,
    input wire logic [15:0] MODULE_STATUS_WORD,
    input wire logic        SPEED_IS_HIGH
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [15:0] st = MODULE_STATUS_WORD;
    int unsigned      stall_q;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // ---------------------------------------------
    // Handshake and status relations
    // ---------------------------------------------
    // Age of a raised read-done flag; a stuck host must end in a sequence error
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) stall_q <= 0;
        else stall_q <= st[6] ? stall_q + 1 : 0;
    end
    sequence take_s; $rose(st[6]); endsequence
    sequence give_s; $rose(st[7]); endsequence
    a_reserved_read_zero: assert property ({st[15:13], st[2:0]} == 6'h00) else $error("reserved status bit set");
    a_take_needs_host: assert property (take_s |-> COMMAND[6] && !st[7]) else $error("early read-done flag");
    a_give_after_drop: assert property (give_s |-> !COMMAND[6] && !st[6]) else $error("early write-done flag");
    a_give_clears: assert property (COMMAND[7] && st[7] |-> ##[1:5] !st[7]) else $error("write-done stuck");
    a_speed_maps: assert property ($changed(SPEED_NORMAL) |-> ##4 st[5] == SPEED_NORMAL && SPEED_IS_HIGH != SPEED_NORMAL)
        else $error("speed flag wrong");
    a_power_maps: assert property ($changed(EXT_POWER_ON) |-> ##4 st[9] == EXT_POWER_ON) else $error("power flag wrong");
    a_ok_drops: assert property ($rose(DIAG_FAULT) |-> ##[1:4] !st[12]) else $error("ok flag kept");
    a_seq_timeout: assert property (stall_q == SEQ_TIMEOUT_CYC + 1 |-> st[10] && !st[6]) else $error("no sequence error");
    a_seq_blocks: assert property (st[10] |=> !$rose(st[6])) else $error("transfer taken in error");
    // Tuned for a half period of ten cycles
    a_pulse_half: assert property (disable iff (!RESETN || NV_WRITE_BUSY) $rose(st[11]) |-> st[11] [*5] ##1 st[11] [*5] ##1 !st[11])
        else $error("heartbeat half period wrong");
    a_pulse_pause: assert property (NV_WRITE_BUSY [*5] |-> $stable(st[11])) else $error("heartbeat ran");
endmodule
bind aout_host_port aout_host_port_props #(.SEQ_TIMEOUT_CYC(SEQ_TIMEOUT_CYC)) chk_u (.*);
`default_nettype wire

// ==== test/host_cpu_model.sv ====
// Behavioural controller CPU for the four-word exchange
`default_nettype none
module host_cpu_model (
    input  wire logic        clk,
    input  wire logic [15:0] status,
    input  wire logic [15:0] result,
    output logic      [15:0] wdata,
    output logic      [15:0] cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    int          lost = 0;
    logic [15:0] got;
    initial begin
        wdata = 16'h0000;
        cmd   = 16'h0000;
    end
    // ---------------------------------------------
    // Handshake tasks
    // ---------------------------------------------
    // Bounded wait; a missing answer is counted rather than hung on
    task automatic wait_bit(input int b, input logic v);
        for (int i = 0; i < 40 && status[b] !== v; i++) @(negedge clk);
        if (status[b] !== v) lost++;
    endtask
    // Full exchange; a stall leaves write-done raised for good
    task automatic xfer(input logic wr, input logic [7:0] p, input logic [15:0] d, input logic stall);
        @(negedge clk);
        wdata = d;
        cmd   = {p, 2'b01, 5'h00, wr};
        wait_bit(6, 1'b1);
        if (!stall) begin
            @(negedge clk) cmd[6] = 1'b0;
            wait_bit(7, 1'b1);
            got = result;
            @(negedge clk) cmd[7] = 1'b1;
            wait_bit(7, 1'b0);
            @(negedge clk) cmd[7] = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the host exchange port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 10;
    localparam int SEQ  = 50;
    logic        REF_CLK = 1'b0, RESETN = 1'b0, spd = 1'b0, pwr = 1'b0, cf = 1'b0, dd = 1'b0, df = 1'b0, nvb = 1'b0;
    logic        hi, bad, s11;
    logic [7:0]  bip = 8'h00, p;
    logic [15:0] wdata, cmd, rres, st, d;
    logic [15:0] mem [62];
    logic [24:0] tbl [10] = '{{8'h01, 16'h4095, 1'b0}, {8'h01, 16'h4096, 1'b1}, {8'h02, 16'h00A0, 1'b1},
        {8'h03, 16'h8001, 1'b0}, {8'h03, 16'hA048, 1'b0}, {8'h03, 16'h2048, 1'b1}, {8'h32, 16'h7999, 1'b0},
        {8'h32, 16'h8001, 1'b1}, {8'h00, 16'h0001, 1'b1}, {8'h62, 16'h0001, 1'b1}};
    int          fails = 0, checks = 0, seed = 32'h54eb, n, k;
    // 200 MHz reference
    always #2.5 REF_CLK = ~REF_CLK;
    aout_host_port #(.PULSE_HALF_CYC(HALF), .SEQ_TIMEOUT_CYC(SEQ)) dut_u (.REF_CLK(REF_CLK), .RESETN(RESETN),
        .WRITE_DATA(wdata), .COMMAND(cmd), .SPEED_NORMAL(spd), .EXT_POWER_ON(pwr), .CONV_FAULT(cf), .DIAG_DONE(dd),
        .DIAG_FAULT(df), .NV_WRITE_BUSY(nvb), .BIPOLAR_POINTS(bip), .READ_RESULT_WORD(rres),
        .MODULE_STATUS_WORD(st), .SPEED_IS_HIGH(hi), .NV_WRITE_REQ(), .PARAM_UPDATE_REQ());
    host_cpu_model host_u (.clk(REF_CLK), .status(st), .result(rres), .wdata(wdata), .cmd(cmd));
    // ---------------------------------------------
    // Checking helpers
    // ---------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        fails += host_u.lost;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        host_u.xfer(1'b0, a, 16'h0000, 1'b0);
        check(host_u.got, e);
    endtask
    function automatic logic [15:0] to_bcd(input int v);
        return {4'((v / 1000) % 10), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction
    task automatic wait_pulse(input logic v);
        for (int i = 0; i < 4 * HALF && st[11] !== v; i++) @(negedge REF_CLK);
    endtask
    // Whole run is near 1000 cycles; the watchdog allows about twelve times that
    initial begin
        #60us;
        fails++;
        give_verdict();
    end
    // Main sequence
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        mem[10] = 16'hFF00;
        mem[14] = 16'hFF00;
        bip = (8'($random(seed)) & 8'hFA) | 8'h04;
        repeat (3) @(negedge REF_CLK);
        check(st, 16'h0000);
        RESETN = 1'b1;
        repeat (4) @(negedge REF_CLK);
        rd_chk(8'h10, 16'hFF00);
        rd_chk(8'h14, 16'hFF00);
        foreach (tbl[i]) begin
            {p, d, bad} = tbl[i];
            host_u.xfer(1'b1, p, d, 1'b0);
            check(16'(st[3]), 16'(bad));
            k = p[7:4] * 10 + p[3:0];
            if (!bad) mem[k] = d;
            if (k > 0 && k < 62) rd_chk(p, mem[k]);
        end
        repeat (10) begin
            k = 1 + {$random(seed)} % 8;
            n = {$random(seed)} % 2048;
            mem[k] = to_bcd(n);
            host_u.xfer(1'b1, 8'(k), mem[k], 1'b0);
            check(16'(st[3]), 16'h0000);
            rd_chk(8'(k), mem[k]);
        end
        spd = 1'b1;
        pwr = 1'b1;
        dd  = 1'b1;
        repeat (6) @(negedge REF_CLK);
        check(16'({st[12], st[9], st[5], hi}), 16'h000E);
        df = 1'b1;
        cf = 1'b1;
        repeat (6) @(negedge REF_CLK);
        check(16'({st[12], st[4]}), 16'h0001);
        cf = 1'b0;
        host_u.xfer(1'b1, 8'h01, 16'h0001, 1'b0);
        check(16'(st[4]), 16'h0000);
        mem[1] = 16'h0001;
        wait_pulse(1'b0);
        wait_pulse(1'b1);
        for (n = 0; n < 4 * HALF && st[11] === 1'b1; n++) @(negedge REF_CLK);
        check(16'(n), 16'(HALF));
        nvb = 1'b1;
        repeat (4) @(negedge REF_CLK);
        s11 = st[11];
        repeat (3 * HALF) @(negedge REF_CLK);
        check(16'(st[11]), 16'(s11));
        nvb = 1'b0;
        wait_pulse(!s11);
        check(16'(st[11]), 16'(!s11));
        host_u.xfer(1'b0, 8'h01, 16'h0000, 1'b1);
        repeat (SEQ + 10) @(negedge REF_CLK);
        check(16'(st[10]), 16'h0001);
        host_u.cmd[6] = 1'b0;
        @(negedge REF_CLK);
        host_u.wdata = 16'h0777;
        host_u.cmd = 16'h0141;
        repeat (10) @(negedge REF_CLK);
        check(16'(st[6]), 16'h0000);
        host_u.cmd[6] = 1'b0;
        @(negedge REF_CLK);
        host_u.cmd[7] = 1'b1;
        repeat (6) @(negedge REF_CLK);
        check(16'(st[10]), 16'h0000);
        host_u.cmd[7] = 1'b0;
        repeat (6) @(negedge REF_CLK);
        rd_chk(8'h01, mem[1]);
        host_u.xfer(1'b1, 8'h14, 16'h0000, 1'b0);
        host_u.xfer(1'b1, 8'h16, 16'h0800, 1'b0);
        host_u.xfer(1'b1, 8'h01, 16'h0900, 1'b0);
        check(16'(st[8]), 16'h0001);
        rd_chk(8'h01, mem[1]);
        give_verdict();
    end
endmodule
`default_nettype wire
